//--- hdl/ext_bus_wait_ctrl.sv
// External bus cycle timing: per-area two/three-state access and wait-state insertion.
// Assumes a requester that drops i_acc_req by the edge that raises o_acc_done and a wait pin sampled
// synchronously to i_mclk; registers reached over Avalon-MM with waitrequest.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Function
// - An area whose selection bit is 0 is accessed in two states.
// - An area whose selection bit is 1 is accessed in three states, all bits reset to 1.
// - The wait mode field picks programmable, none, pin-driven or pin auto-wait, reset 00.
// - The wait count field inserts zero to three wait states, reset 11.
module ext_bus_wait_ctrl (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [ext_bus_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_acc_req,
	input wire logic [ext_bus_pkg::AREA_W-1:0] i_acc_area,
	input wire logic i_acc_write,
	input wire logic i_wait_n,
	output logic o_as_n,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic o_acc_done,
	output logic o_busy
);
	import ext_bus_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Register slave
	logic [7:0] area_three_state_bits;
	logic wait_mode_sel_hi;
	logic wait_mode_sel_lo;
	logic wait_count_hi;
	logic wait_count_lo;
	logic [7:0] area_sel_next;
	logic [1:0] wait_mode_next;
	logic [1:0] wait_count_next;
	logic waitreq_reg;
	logic [31:0] rdata_reg;

	wire logic [1:0] wait_mode = {wait_mode_sel_hi, wait_mode_sel_lo};
	wire logic [1:0] wait_count = {wait_count_hi, wait_count_lo};
	wire logic bus_req = i_avs_read | i_avs_write;
	// Write takes effect only at the edge where waitrequest is seen low
	wire logic bus_go = bus_req & ~waitreq_reg;
	wire logic hit_area = (i_avs_address == AREA_SEL_ADDR);
	wire logic hit_wait = (i_avs_address == WAIT_CTL_ADDR);
	wire logic wr_lane0 = bus_go & i_avs_write & i_avs_byteenable[0];
	wire logic [7:0] wait_ctl_rd = {WAIT_CTL_RSVD, wait_mode, wait_count};
	// Unmapped addresses read as zero and ignore writes
	wire logic [7:0] rd_byte = hit_area ? area_three_state_bits :
		hit_wait ? wait_ctl_rd : 8'h00;

	assign area_sel_next = (wr_lane0 && hit_area) ? i_avs_writedata[7:0]
		: area_three_state_bits;
	assign wait_mode_next = (wr_lane0 && hit_wait)
		? i_avs_writedata[WAIT_MODE_LSB +: 2] : wait_mode;
	assign wait_count_next = (wr_lane0 && hit_wait)
		? i_avs_writedata[WAIT_COUNT_LSB +: 2] : wait_count;

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			area_three_state_bits <= AREA_SEL_RST;
			{wait_mode_sel_hi, wait_mode_sel_lo} <= WAIT_MODE_RST;
			{wait_count_hi, wait_count_lo} <= WAIT_COUNT_RST;
		end else begin
			area_three_state_bits <= area_sel_next;
			{wait_mode_sel_hi, wait_mode_sel_lo} <= wait_mode_next;
			{wait_count_hi, wait_count_lo} <= wait_count_next;
		end
	end

	// One wait cycle per access keeps read data registered
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			waitreq_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
		end else begin
			waitreq_reg <= ~(bus_req & waitreq_reg);
			rdata_reg <= {24'h00_0000, rd_byte};
		end
	end

	assign o_avs_waitrequest = waitreq_reg;
	assign o_avs_readdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// Bus cycle sequencer
	bus_state_e state_reg;
	bus_state_e state_next;
	logic three_reg;
	logic wr_reg;
	logic [1:0] mode_reg;
	logic as_n_reg;
	logic rd_n_reg;
	logic wr_n_reg;
	logic done_reg;
	logic busy_reg;
	logic [1:0] waits_left;

	wire logic accept = (state_reg == S_IDLE) & i_acc_req;
	wire logic area_three = area_three_state_bits[i_acc_area];
	// Programmable waits always, auto-wait only when the pin asks
	wire logic use_count = (mode_reg == WM_PROG) | ((mode_reg == WM_AUTO) & ~i_wait_n);
	wire logic [1:0] load_waits = (three_reg & use_count) ? wait_count : 2'h0;
	wire logic in_t2 = (state_reg == S_T2);
	wire logic in_tw = (state_reg == S_TW);
	// pin mode waits on the pin
	wire logic pin_wait = (mode_reg == WM_PIN) & ~i_wait_n;
	wire logic enter_tw = three_reg & ((mode_reg == WM_PIN) ? pin_wait : load_waits != 2'h0);
	wire logic leave_tw = (mode_reg == WM_PIN) ? ~pin_wait : (waits_left <= 2'h1);

	ext_wait_counter u_wait_cnt (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_load(in_t2),
		.i_load_val(load_waits),
		.i_dec(in_tw),
		.o_count(waits_left)
	);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: begin
				if (i_acc_req)
					state_next = S_T1;
			end
			S_T1: state_next = S_T2;
			S_T2: begin
				if (!three_reg)
					state_next = S_IDLE;
				else if (enter_tw)
					state_next = S_TW;
				else
					state_next = S_T3;
			end
			S_TW: begin
				if (leave_tw)
					state_next = S_T3;
			end
			S_T3: state_next = S_IDLE;
			default: state_next = S_IDLE;
		endcase
	end

	wire logic active_next = (state_next != S_IDLE);
	wire logic wr_next = accept ? i_acc_write : wr_reg;
	wire logic finish = (state_reg != S_IDLE) & (state_next == S_IDLE);

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			state_reg <= S_IDLE;
			three_reg <= 1'b1;
			wr_reg <= 1'b0;
			mode_reg <= WAIT_MODE_RST;
			as_n_reg <= 1'b1;
			rd_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
			done_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (accept) begin
				three_reg <= area_three;
				mode_reg <= wait_mode;
			end
			wr_reg <= wr_next;
			as_n_reg <= ~active_next;
			rd_n_reg <= ~(active_next & ~wr_next);
			wr_n_reg <= ~(active_next & wr_next & (state_next != S_T1));
			done_reg <= finish;
			// Own flop so the busy output is not an inverter behind a register
			busy_reg <= active_next;
		end
	end

	assign o_as_n = as_n_reg;
	assign o_rd_n = rd_n_reg;
	assign o_wr_n = wr_n_reg;
	assign o_acc_done = done_reg;
	assign o_busy = busy_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic [2:0] tw_seen_reg;
	logic [1:0] wc_at_t2_reg;
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			tw_seen_reg <= 3'h0;
			wc_at_t2_reg <= 2'h0;
		end else begin
			tw_seen_reg <= (state_reg == S_T1) ? 3'h0 : tw_seen_reg + {2'h0, in_tw};
			if (in_t2)
				wc_at_t2_reg <= wait_count;
		end
	end

	sequence s_two_tail;
		(state_reg == S_T2) ##1 (state_reg == S_IDLE);
	endsequence
	sequence s_three_tail;
		(state_reg == S_T2) ##1 (state_reg == S_T3) ##1 (state_reg == S_IDLE);
	endsequence

	property p_two_state;
		@(posedge i_mclk) disable iff (!i_rstn)
		(state_reg == S_T1 && !three_reg) |=> s_two_tail;
	endproperty
	a_two_state: assert property (p_two_state)
		else $error("two-state access did not end after T2");

	property p_three_nowait;
		@(posedge i_mclk) disable iff (!i_rstn)
		(state_reg == S_T1 && three_reg && mode_reg == WM_NONE) |=> s_three_tail;
	endproperty
	a_three_nowait: assert property (p_three_nowait)
		else $error("three-state access without waits took wrong states");

	property p_reset_vals;
		@(posedge i_mclk) !i_rstn |=> area_three_state_bits == AREA_SEL_RST
			&& wait_mode == WAIT_MODE_RST && wait_count == WAIT_COUNT_RST;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("register reset values wrong");

	property p_pin_hold;
		@(posedge i_mclk) disable iff (!i_rstn)
		(in_tw && mode_reg == WM_PIN && !i_wait_n) |=> (state_reg == S_TW);
	endproperty
	a_pin_hold: assert property (p_pin_hold)
		else $error("pin wait released while pin low");

	property p_prog_count;
		@(posedge i_mclk) disable iff (!i_rstn)
		(state_reg == S_T3 && mode_reg == WM_PROG) |-> (tw_seen_reg == {1'b0, wc_at_t2_reg});
	endproperty
	a_prog_count: assert property (p_prog_count)
		else $error("programmable wait count mismatch");

	property p_none_mode;
		@(posedge i_mclk) disable iff (!i_rstn)
		(in_t2 && mode_reg == WM_NONE) |=> (state_reg != S_TW);
	endproperty
	a_none_mode: assert property (p_none_mode)
		else $error("wait inserted in no-wait mode");

	property p_two_nowait;
		@(posedge i_mclk) disable iff (!i_rstn)
		(in_t2 && !three_reg) |=> (state_reg != S_TW) && o_acc_done;
	endproperty
	a_two_nowait: assert property (p_two_nowait)
		else $error("wait state on two-state area");

	property p_reg_write;
		@(posedge i_mclk) disable iff (!i_rstn)
		(wr_lane0 && hit_wait) |=> (wait_count == $past(i_avs_writedata[1:0]))
			&& o_avs_waitrequest;
	endproperty
	a_reg_write: assert property (p_reg_write)
		else $error("wait control write not stored");
endmodule : ext_bus_wait_ctrl

//--- hdl/ext_bus_pkg.sv
// Constants for the external bus state and wait controller.
// Assumes a 32-bit register slave with byte addresses of four times the index.
package ext_bus_pkg;
	localparam int ADDR_W = 10;
	localparam int AREA_W = 3;
	localparam int AREA_N = 8;
	// Register indices; byte address is the index times four
	localparam logic [7:0] AREA_SEL_IDX = 8'hed;
	localparam logic [7:0] WAIT_CTL_IDX = 8'hee;
	localparam logic [ADDR_W-1:0] AREA_SEL_ADDR = {AREA_SEL_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] WAIT_CTL_ADDR = {WAIT_CTL_IDX, 2'b00};
	// Reset values and field layout
	localparam logic [7:0] AREA_SEL_RST = 8'hff;
	localparam logic [1:0] WAIT_MODE_RST = 2'h0;
	localparam logic [1:0] WAIT_COUNT_RST = 2'h3;
	localparam logic [3:0] WAIT_CTL_RSVD = 4'hf;
	localparam int WAIT_MODE_LSB = 2;
	localparam int WAIT_COUNT_LSB = 0;
	// Wait modes
	localparam logic [1:0] WM_PROG = 2'h0;
	localparam logic [1:0] WM_NONE = 2'h1;
	localparam logic [1:0] WM_PIN = 2'h2;
	localparam logic [1:0] WM_AUTO = 2'h3;
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_T1 = 5'b00010,
		S_T2 = 5'b00100,
		S_TW = 5'b01000,
		S_T3 = 5'b10000
	} bus_state_e;
endpackage : ext_bus_pkg

//--- hdl/ext_wait_counter.sv
// Down counter holding the wait states still to insert in one access.
// Assumes the caller loads it once per access and decrements it per wait state.
`timescale 1ns/10ps
module ext_wait_counter (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_load,
	input wire logic [1:0] i_load_val,
	input wire logic i_dec,
	output logic [1:0] o_count
);
	logic [1:0] count_reg;
	wire logic [1:0] count_next = i_load ? i_load_val :
		(i_dec && count_reg != 2'h0) ? count_reg - 2'h1 : count_reg;

	always_ff @(posedge i_mclk) begin
		if (!i_rstn)
			count_reg <= 2'h0;
		else
			count_reg <= count_next;
	end

	assign o_count = count_reg;
endmodule : ext_wait_counter

//--- verification/ext_bus_mem_model.sv
// Behavioural external memory that stretches accesses through the wait pin.
// Assumes strobes change just after the rising edge of i_mclk.
`timescale 1ns/10ps
module ext_bus_mem_model (
	input wire logic i_mclk,
	input wire logic i_as_n,
	input wire logic [1:0] i_hold,
	output logic o_wait_n
);
	logic [3:0] state_cnt_reg;
	always_ff @(posedge i_mclk) begin
		state_cnt_reg <= i_as_n ? 4'h0 : state_cnt_reg + 4'h1;
	end
	// Low from the second state for i_hold cycles; pull-up holds it high between accesses
	assign o_wait_n = i_as_n || state_cnt_reg == 4'h0 || state_cnt_reg > {2'b00, i_hold};
endmodule : ext_bus_mem_model

//--- verification/ext_bus_wait_ctrl_tb_top.sv
// Self-checking bench: register access over Avalon-MM and timed external accesses.
// Assumes the external memory model drives the wait pin.
`timescale 1ns/10ps
module ext_bus_wait_ctrl_tb_top;
	import ext_bus_pkg::*;
	logic i_mclk, i_rstn, i_avs_read, i_avs_write, i_acc_req, i_acc_write, i_wait_n;
	logic [ADDR_W-1:0] i_avs_address;
	logic [31:0] i_avs_writedata, o_avs_readdata, rd;
	logic [3:0] i_avs_byteenable;
	logic o_avs_waitrequest, o_as_n, o_rd_n, o_wr_n, o_acc_done, o_busy;
	logic [AREA_W-1:0] i_acc_area;
	logic [1:0] hold;
	int miscompares = 0;
	int check_count = 0;
	int test_num = 0;

	ext_bus_wait_ctrl ext_bus_wait_ctrl_inst (.i_mclk(i_mclk), .i_rstn(i_rstn),
		.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
		.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
		.i_acc_req(i_acc_req), .i_acc_area(i_acc_area), .i_acc_write(i_acc_write),
		.i_wait_n(i_wait_n), .o_as_n(o_as_n), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n),
		.o_acc_done(o_acc_done), .o_busy(o_busy));
	ext_bus_mem_model ext_bus_mem_model_inst (.i_mclk(i_mclk), .i_as_n(o_as_n),
		.i_hold(hold), .o_wait_n(i_wait_n));

	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task conclude();
		$display("checks=%0d mismatches=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	task av(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		@(posedge i_mclk);
		i_avs_write <= wr;
		i_avs_read <= !wr;
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_byteenable <= be;
		do begin
			@(posedge i_mclk);
			n++;
		end while (o_avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			miscompares++;
		rd = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
	endtask : av

	// Request is dropped at the edge that should launch done, so it is not retaken
	task acc(input logic [AREA_W-1:0] a, input logic wr, input int exp);
		int k;
		k = 0;
		@(posedge i_mclk);
		i_acc_req <= 1'b1;
		i_acc_area <= a;
		i_acc_write <= wr;
		@(posedge i_mclk);
		do begin
			@(posedge i_mclk);
			k++;
			if (k == exp - 1)
				i_acc_req <= 1'b0;
			if (k == 2)
				chk({28'h0, o_busy, o_as_n, o_rd_n, o_wr_n}, {28'h0, 1'b1, 1'b0, wr, !wr});
		end while (o_acc_done !== 1'b1 && k < 40);
		if (k < exp - 1)
			i_acc_req <= 1'b0;
		chk(k, exp);
		chk({28'h0, o_busy, o_as_n, o_rd_n, o_wr_n}, 32'h0000_0007);
	endtask : acc

	task run(input logic [7:0] sel, input logic [3:0] wc, input logic [1:0] h, input int w);
		hold <= h;
		av(1'b1, AREA_SEL_ADDR, {24'h0, sel}, 4'hf);
		av(1'b1, WAIT_CTL_ADDR, {28'h0, wc}, 4'hf);
		av(1'b0, WAIT_CTL_ADDR, 32'h0, 4'hf);
		chk(rd, {24'h0, 4'hf, wc});
		av(1'b0, AREA_SEL_ADDR, 32'h0, 4'hf);
		chk(rd, {24'h0, sel});
		for (int a = 0; a < 8; a++)
			acc(a[2:0], a[0], sel[a] ? 4 + w : 3);
		test_num++;
		$display("test %0d done", test_num);
	endtask : run

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end

	// Whole run is about 650 cycles; limit leaves wide margin
	initial begin
		#2000000;
		miscompares++;
		conclude();
	end

	initial begin
		i_rstn = 1'b0;
		{i_avs_read, i_avs_write, i_acc_req, i_acc_write} = 4'h0;
		i_avs_address = '0;
		i_avs_writedata = 32'h0;
		i_avs_byteenable = 4'h0;
		i_acc_area = '0;
		hold = 2'h0;
		repeat (8) @(posedge i_mclk);
		i_rstn <= 1'b1;
		av(1'b0, AREA_SEL_ADDR, 32'h0, 4'hf);
		chk(rd, 32'h0000_00ff);
		av(1'b0, WAIT_CTL_ADDR, 32'h0, 4'hf);
		chk(rd, 32'h0000_00f3);
		acc(3'h2, 1'b0, 7);
		// Writes without the low byte lane or to a hole must change nothing
		av(1'b1, AREA_SEL_ADDR, 32'h0, 4'he);
		av(1'b1, 10'h3bc, 32'h0, 4'hf);
		av(1'b0, 10'h3bc, 32'h0, 4'hf);
		chk(rd, 32'h0);
		av(1'b0, AREA_SEL_ADDR, 32'h0, 4'hf);
		chk(rd, 32'h0000_00ff);
		$display("test 0 done");
		run(8'ha5, 4'h0, 2'h0, 0);
		run(8'ha5, 4'h1, 2'h0, 1);
		run(8'ha5, 4'h2, 2'h0, 2);
		run(8'ha5, 4'h3, 2'h0, 3);
		run(8'h5a, 4'h7, 2'h2, 0);
		run(8'h5a, 4'hb, 2'h2, 2);
		run(8'h5a, 4'hb, 2'h3, 3);
		run(8'h5a, 4'hf, 2'h1, 3);
		run(8'h5a, 4'he, 2'h0, 0);
		run(8'h00, 4'h3, 2'h0, 0);
		conclude();
	end
endmodule : ext_bus_wait_ctrl_tb_top
